// [grouped_priority_interrupt_ctrl.sv]
// Grouped four-level priority interrupt controller with its register file.
// What this block does
// - Global enable low blocks every source regardless of source enables.
// - Timer 2 overflow passes only with its enable and global enable.
// - Serial port request passes only with its enable and global enable.
// - Timer 0 and timer 1 overflow pass only with own and global enable.
// - External 0 and 1 pass only with own and global enable.
// - Over-current limit passes only with high-enable bit 7 and global enable.
// - Watchdog passes only with its enable, global enable and mode select.
// - General PWM passes only with high-enable bit 4 and global enable.
// - Motor PWM maximum passes only with high-enable bit 3 and global enable.
// - Motor PWM minimum passes only with high-enable bit 2 and global enable.
// - Hall (bit 1) and over-current short (bit 0) also need global enable.
// - Request register holds seven flags, bit 5 unused, all software read/write.
// - Fourteen sources sort into six groups, each with one of four levels.
// - Low priority register bits 0 to 5 hold group low bits.
// - High priority register bits 0 to 5 hold group high bits.
// - Group level is high bit and low bit; 11 is highest.
// - Low enable register: global 7, T2 5, serial 4, T1 3, X1 2, T0 1, X0 0.
// - Ext, timer, serial and capture hold a level high; the other events set sticky request flags.
// - Group membership and order fixed; group 0 and first-listed rank first.
// - Vector address is 0x0003 plus eight times the source number.
`timescale 1ns/1ps
`include "grouped_priority_interrupt_ctrl_regs.svh"

module grouped_priority_interrupt_ctrl (
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst,
  input  wire grouped_priority_interrupt_ctrl_pkg::reg_req_s regReq,
  output logic [7:0]                                     regRdata,
  input  wire logic                                      ext0Request,
  input  wire logic                                      ext1Request,
  input  wire logic                                      timer0OverflowRequest,
  input  wire logic                                      timer1OverflowRequest,
  input  wire logic                                      timer2OverflowRequest,
  input  wire logic                                      serialRequest,
  input  wire logic                                      captureRequest,
  input  wire logic                                      watchdogIrqModeSelect,
  input  wire logic                                      overcurrentLimitEvent,
  input  wire logic                                      watchdogEvent,
  input  wire logic                                      generalPwmEvent,
  input  wire logic                                      motorPwmMaxEvent,
  input  wire logic                                      motorPwmMinEvent,
  input  wire logic                                      hallEvent,
  input  wire logic                                      overcurrentShortEvent,
  input  wire logic                                      vectorTaken,
  input  wire logic                                      serviceReturn,
  output grouped_priority_interrupt_ctrl_pkg::vector_s   vectorOut,
  output logic [3:0]                                     activeLevels
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] enableLow;
    logic [7:0] enableHigh;
    logic [7:0] prioLow;
    logic [7:0] prioHigh;
    logic [7:0] requestFlags;
    logic [7:0] rdata;
    logic [3:0] inService;
    grouped_priority_interrupt_ctrl_pkg::vector_s vec;
  } state_s;

  state_s st;
  state_s next_st;

  logic [15:0] rawReq;
  logic [15:0] gated;
  logic [15:0] permit;
  logic [7:0]  flagSet;
  logic        globalEn;

  // Slot order by group, then position inside the group; 5'h1F pads unused slots.
  localparam int NUM_SLOTS = 18;
  localparam logic [4:0] SLOT_SRC [NUM_SLOTS] = '{
    5'h00, 5'h1F, 5'h1F,
    5'h0E, 5'h01, 5'h1F,
    5'h08, 5'h09, 5'h02,
    5'h0A, 5'h0B, 5'h03,
    5'h0C, 5'h04, 5'h1F,
    5'h0F, 5'h05, 5'h07
  };

  // ****************************************************************
  // Source gating
  // ****************************************************************
  assign flagSet = {overcurrentLimitEvent, watchdogEvent, 1'b0, generalPwmEvent,
                    motorPwmMaxEvent, motorPwmMinEvent, hallEvent, overcurrentShortEvent};
  assign globalEn = st.enableLow[`BIT_GLOBAL_IRQ_ENABLE];

  always_comb begin
    rawReq = 16'h0000;
    permit = 16'h0000;
    rawReq[0]  = ext0Request;
    rawReq[1]  = timer0OverflowRequest;
    rawReq[2]  = ext1Request;
    rawReq[3]  = timer1OverflowRequest;
    rawReq[4]  = serialRequest;
    rawReq[5]  = timer2OverflowRequest;
    rawReq[7]  = captureRequest;
    rawReq[8]  = st.requestFlags[`BIT_OVERCURRENT_SHORT];
    rawReq[9]  = st.requestFlags[`BIT_HALL];
    rawReq[10] = st.requestFlags[`BIT_MOTOR_PWM_MIN];
    rawReq[11] = st.requestFlags[`BIT_MOTOR_PWM_MAX];
    rawReq[12] = st.requestFlags[`BIT_GENERAL_PWM];
    rawReq[14] = st.requestFlags[`BIT_WATCHDOG];
    rawReq[15] = st.requestFlags[`BIT_OVERCURRENT_LIMIT];
    permit[0]  = st.enableLow[0];
    permit[1]  = st.enableLow[1];
    permit[2]  = st.enableLow[2];
    permit[3]  = st.enableLow[3];
    permit[4]  = st.enableLow[4];
    permit[5]  = st.enableLow[5];
    // The capture unit keeps its own enable, so only the global gate applies here.
    permit[7]  = 1'b1;
    permit[8]  = st.enableHigh[`BIT_OVERCURRENT_SHORT];
    permit[9]  = st.enableHigh[`BIT_HALL];
    permit[10] = st.enableHigh[`BIT_MOTOR_PWM_MIN];
    permit[11] = st.enableHigh[`BIT_MOTOR_PWM_MAX];
    permit[12] = st.enableHigh[`BIT_GENERAL_PWM];
    permit[14] = st.enableHigh[`BIT_WATCHDOG] & watchdogIrqModeSelect;
    permit[15] = st.enableHigh[`BIT_OVERCURRENT_LIMIT];
  end

  assign gated = globalEn ? (rawReq & permit) : 16'h0000;

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  logic [1:0] slotLevel [NUM_SLOTS];
  logic       slotReq   [NUM_SLOTS];

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
      localparam int GRP = g / 3;
      assign slotLevel[g] = {st.prioHigh[GRP], st.prioLow[GRP]};
      assign slotReq[g]   = (SLOT_SRC[g] != 5'h1F) && gated[SLOT_SRC[g][3:0]];
    end
  endgenerate

  logic       winFound;
  logic [1:0] winLevel;
  logic [3:0] winSrc;

  // Strictly greater keeps the earlier slot on a tie, giving group order.
  always_comb begin
    winFound = 1'b0;
    winLevel = 2'b00;
    winSrc   = 4'h0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (slotReq[i] && (!winFound || slotLevel[i] > winLevel)) begin
        winFound = 1'b1;
        winLevel = slotLevel[i];
        winSrc   = SLOT_SRC[i][3:0];
      end
    end
  end

  // Current running level: highest bit set in the in-service stack.
  logic       anyInService;
  logic [1:0] curLevel;
  always_comb begin
    anyInService = |st.inService;
    curLevel     = 2'b00;
    for (int k = 0; k < 4; k++) begin
      if (st.inService[k]) begin
        curLevel = 2'(k);
      end
    end
  end

  logic canPreempt;
  assign canPreempt = winFound && (!anyInService || winLevel > curLevel);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (regReq.rd) begin
      unique case (regReq.addr)
        `OFS_SOURCE_ENABLE_LOW:        next_st.rdata = st.enableLow;
        `OFS_SOURCE_ENABLE_HIGH:       next_st.rdata = st.enableHigh;
        `OFS_GROUP_PRIORITY_LOW_BITS:  next_st.rdata = st.prioLow;
        `OFS_GROUP_PRIORITY_HIGH_BITS: next_st.rdata = st.prioHigh;
        `OFS_REQUEST_FLAGS:            next_st.rdata = st.requestFlags;
        default:                       next_st.rdata = 8'h00;
      endcase
    end
    if (regReq.wr) begin
      unique case (regReq.addr)
        `OFS_SOURCE_ENABLE_LOW:
          next_st.enableLow = regReq.wdata & `MASK_ENABLE_LOW;
        `OFS_SOURCE_ENABLE_HIGH:
          next_st.enableHigh = regReq.wdata & `MASK_ENABLE_HIGH;
        `OFS_GROUP_PRIORITY_LOW_BITS:
          next_st.prioLow = regReq.wdata & `MASK_PRIORITY;
        `OFS_GROUP_PRIORITY_HIGH_BITS:
          next_st.prioHigh = regReq.wdata & `MASK_PRIORITY;
        `OFS_REQUEST_FLAGS:
          next_st.requestFlags = regReq.wdata & `MASK_REQUEST_FLAGS;
        default: ;
      endcase
    end
    // Hardware setting a flag wins over a software clear in the same cycle.
    next_st.requestFlags = next_st.requestFlags | (flagSet & `MASK_REQUEST_FLAGS);

    next_st.vec.valid   = canPreempt;
    next_st.vec.number  = winSrc;
    next_st.vec.level   = winLevel;
    next_st.vec.address = `VECTOR_BASE + {9'h000, winSrc, 3'b000};
    if (vectorTaken && st.vec.valid) begin
      next_st.inService[st.vec.level] = 1'b1;
      next_st.vec.valid = 1'b0;
    end else if (serviceReturn) begin
      for (int k = 3; k >= 0; k--) begin
        if (st.inService[k] && 2'(k) == curLevel) begin
          next_st.inService[k] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata     = st.rdata;
  assign vectorOut    = st.vec;
  assign activeLevels = st.inService;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_GLOBAL_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    !globalEn |=> !vectorOut.valid || $past(vectorTaken))
    else $error("Vector offered while global enable off.");
  AST_WDOG_MODE: assert property (@(posedge ref_clk) disable iff (rst)
    !watchdogIrqModeSelect |=> !(vectorOut.valid && vectorOut.number == 4'hE))
    else $error("Watchdog passed without mode select.");
  AST_VEC_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    vectorOut.valid |-> vectorOut.address == 16'h0003 + 16'(vectorOut.number) * 16'd8)
    else $error("Vector address wrong.");
  AST_FLAG_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
    hallEvent |=> requestFlags_hall())
    else $error("Hall flag lost.");
  AST_RESET_CLEAR: assert property (@(posedge ref_clk)
    rst |=> st.enableLow == 8'h00 && st.prioHigh == 8'h00 && !vectorOut.valid)
    else $error("Registers not cleared by reset.");
  AST_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
    (regReq.rd && regReq.addr == 8'hB9) |=> regRdata == $past(st.prioHigh) && regRdata[7:6] == 2'b00)
    else $error("High priority readback wrong.");
  AST_PREEMPT: assert property (@(posedge ref_clk) disable iff (rst)
    vectorOut.valid && anyInService |-> vectorOut.level > curLevel || $past(vectorTaken))
    else $error("Vector does not pre-empt.");
  AST_T2_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h5) |-> $past(st.enableLow[5] && globalEn))
    else $error("Timer 2 vector without enables.");

  // ****************************************************************
  // Gate, level and bookkeeping checks
  // ****************************************************************

  AST_T0_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h1) |-> $past(st.enableLow[1] && globalEn))
    else $error("Timer 0 vector without enables.");

  AST_T1_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h3) |-> $past(st.enableLow[3] && globalEn))
    else $error("Timer 1 vector without enables.");

  AST_EXT0_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h0) |-> $past(st.enableLow[0] && globalEn))
    else $error("External 0 vector without enables.");

  AST_EXT1_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h2) |-> $past(st.enableLow[2] && globalEn))
    else $error("External 1 vector without enables.");

  AST_SERIAL_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h4) |-> $past(st.enableLow[4] && globalEn))
    else $error("Serial vector without enables.");

  AST_OC_LIMIT_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'hF) |-> $past(st.enableHigh[7] && globalEn))
    else $error("Over-current limit vector without enables.");

  AST_WDOG_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'hE)
      |-> $past(st.enableHigh[6] && watchdogIrqModeSelect && globalEn))
    else $error("Watchdog vector without enables.");

  AST_GEN_PWM_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'hC) |-> $past(st.enableHigh[4] && globalEn))
    else $error("General PWM vector without enables.");

  AST_MOTOR_MAX_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'hB) |-> $past(st.enableHigh[3] && globalEn))
    else $error("Motor PWM maximum vector without enables.");

  AST_MOTOR_MIN_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'hA) |-> $past(st.enableHigh[2] && globalEn))
    else $error("Motor PWM minimum vector without enables.");

  AST_HALL_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h9) |-> $past(st.enableHigh[1] && globalEn))
    else $error("Hall vector without enables.");

  AST_OC_SHORT_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h8) |-> $past(st.enableHigh[0] && globalEn))
    else $error("Over-current short vector without enables.");

  AST_NO_UNUSED_NUMBER: assert property (@(posedge ref_clk) disable iff (rst)
    vectorOut.valid |-> vectorOut.number != 4'h6 && vectorOut.number != 4'hD)
    else $error("Vector offered for an unused number.");

  AST_PRIO_LOW_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    st.prioLow[7:6] == 2'b00)
    else $error("Low priority reserved bits set.");

  AST_PRIO_HIGH_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    st.prioHigh[7:6] == 2'b00)
    else $error("High priority reserved bits set.");

  AST_ENABLE_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    st.enableLow[6] == 1'b0 && st.enableHigh[5] == 1'b0)
    else $error("Enable reserved bits set.");

  AST_REQ_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    st.requestFlags[5] == 1'b0)
    else $error("Request reserved bit set.");

  AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
    (st.requestFlags[0] && !(regReq.wr && regReq.addr == 8'hC0)) |=> st.requestFlags[0])
    else $error("Short flag dropped without a write.");

  AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !regReq.rd |=> regRdata == 8'h00)
    else $error("Read data not zero outside a read.");

  AST_LEVEL_G0: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h0)
      |-> vectorOut.level == $past({st.prioHigh[0], st.prioLow[0]}))
    else $error("Group 0 level wrong.");

  AST_LEVEL_G5: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorOut.valid && vectorOut.number == 4'h5)
      |-> vectorOut.level == $past({st.prioHigh[5], st.prioLow[5]}))
    else $error("Group 5 level wrong.");

  AST_EXT0_WINS: assert property (@(posedge ref_clk) disable iff (rst)
    (gated[0] && !vectorTaken && !anyInService && st.prioLow == 8'h00
      && st.prioHigh == 8'h00) |=> vectorOut.valid && vectorOut.number == 4'h0)
    else $error("Group 0 did not win at equal levels.");

  AST_TAKE_SETS: assert property (@(posedge ref_clk) disable iff (rst)
    (vectorTaken && vectorOut.valid)
      |=> !vectorOut.valid && activeLevels[$past(vectorOut.level)])
    else $error("Accepted vector not marked in service.");

  AST_RETURN_POP: assert property (@(posedge ref_clk) disable iff (rst)
    (serviceReturn && !vectorTaken && anyInService)
      |=> activeLevels == ($past(activeLevels) & ~(4'h1 << $past(curLevel))))
    else $error("Return did not end the highest level.");

  function automatic logic requestFlags_hall();
    return st.requestFlags[`BIT_HALL];
  endfunction : requestFlags_hall

endmodule : grouped_priority_interrupt_ctrl

// [grouped_priority_interrupt_ctrl_pkg.sv]
// Types shared by the interrupt controller and its environment.
package grouped_priority_interrupt_ctrl_pkg;

  // Register bus request from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // Vector hand-off towards the core.
  typedef struct packed {
    logic        valid;
    logic [3:0]  number;
    logic [15:0] address;
    logic [1:0]  level;
  } vector_s;

  typedef enum logic [3:0] {
    SRC_EXT0     = 4'h0,
    SRC_TIMER0   = 4'h1,
    SRC_EXT1     = 4'h2,
    SRC_TIMER1   = 4'h3,
    SRC_SERIAL   = 4'h4,
    SRC_TIMER2   = 4'h5,
    SRC_CAPTURE  = 4'h7,
    SRC_OC_SHORT = 4'h8,
    SRC_HALL     = 4'h9,
    SRC_MOTOR_PWM_MIN   = 4'hA,
    SRC_MOTOR_PWM_MAX   = 4'hB,
    SRC_GENERAL_PWM     = 4'hC,
    SRC_WATCHDOG = 4'hE,
    SRC_OC_LIMIT = 4'hF
  } source_e;

endpackage : grouped_priority_interrupt_ctrl_pkg

// [grouped_priority_interrupt_ctrl_regs.svh]
// Register offsets, field positions, reset values and vector constants.
`ifndef GROUPED_PRIORITY_INTERRUPT_CTRL_REGS_SVH
`define GROUPED_PRIORITY_INTERRUPT_CTRL_REGS_SVH

`define OFS_SOURCE_ENABLE_LOW        8'hA8
`define OFS_GROUP_PRIORITY_LOW_BITS  8'hA9
`define OFS_SOURCE_ENABLE_HIGH       8'hB8
`define OFS_GROUP_PRIORITY_HIGH_BITS 8'hB9
`define OFS_REQUEST_FLAGS            8'hC0

`define RST_REG                      8'h00

`define BIT_GLOBAL_IRQ_ENABLE        7
`define BIT_WATCHDOG                 6
`define BIT_GENERAL_PWM              4
`define BIT_MOTOR_PWM_MAX            3
`define BIT_MOTOR_PWM_MIN            2
`define BIT_HALL                     1
`define BIT_OVERCURRENT_SHORT        0
`define BIT_OVERCURRENT_LIMIT        7

`define MASK_ENABLE_LOW              8'hBF
`define MASK_ENABLE_HIGH             8'hDF
`define MASK_REQUEST_FLAGS           8'hDF
`define MASK_PRIORITY                8'h3F

`define VECTOR_BASE                  16'h0003
`define VECTOR_STRIDE_SHIFT          3

`endif

// [grouped_priority_interrupt_ctrl_tb.sv]
// Self-checking bench for the grouped priority interrupt controller.
`timescale 1ns/1ps
module grouped_priority_interrupt_ctrl_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  grouped_priority_interrupt_ctrl_pkg::reg_req_s regReq = '0;
  grouped_priority_interrupt_ctrl_pkg::vector_s  vectorOut;
  logic [7:0]  regRdata;
  logic [3:0]  activeLevels;
  logic [3:0]  takenNumber;
  logic [15:0] req = 16'h0000;
  logic        wdMode = 1'b0;
  logic        takeEn = 1'b0;
  logic        retCmd = 1'b0;
  logic [3:0]  takeDelay = 4'h0;
  logic        vectorTaken;
  logic        serviceReturn;
  int          err_count = 0;
  int          check_count = 0;
  int          srcs [13] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 14, 15};

  always #2.5 ref_clk = ~ref_clk;

  grouped_priority_interrupt_ctrl grouped_priority_interrupt_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .ext0Request(req[0]), .timer0OverflowRequest(req[1]), .ext1Request(req[2]),
    .timer1OverflowRequest(req[3]), .serialRequest(req[4]),
    .timer2OverflowRequest(req[5]), .captureRequest(req[7]),
    .watchdogIrqModeSelect(wdMode), .overcurrentShortEvent(req[8]),
    .hallEvent(req[9]), .motorPwmMinEvent(req[10]), .motorPwmMaxEvent(req[11]),
    .generalPwmEvent(req[12]), .watchdogEvent(req[14]),
    .overcurrentLimitEvent(req[15]), .vectorTaken(vectorTaken),
    .serviceReturn(serviceReturn), .vectorOut(vectorOut), .activeLevels(activeLevels));

  processor_core_model processor_core_model_i (
    .ref_clk(ref_clk), .rst(rst), .vectorOut(vectorOut), .takeEn(takeEn),
    .takeDelay(takeDelay), .retCmd(retCmd), .vectorTaken(vectorTaken),
    .serviceReturn(serviceReturn), .takenNumber(takenNumber));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task complete_run();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    #1 chk("regRdata", {8'h00, exp}, {8'h00, regRdata});
  endtask : rd

  // An offer that never comes ends the run; an unwanted one is only counted.
  task expV(input logic on, input logic [3:0] num, input logic [1:0] lvl);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && seen !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1 seen = vectorOut.valid;
    end
    chk("vectorOut.valid", {15'h0, on}, {15'h0, seen});
    if (on) begin
      chk("vectorOut.number", {12'h0, num}, {12'h0, vectorOut.number});
      chk("vectorOut.address", 16'h0003 + {num, 3'b000}, vectorOut.address);
      chk("vectorOut.level", {14'h0, lvl}, {14'h0, vectorOut.level});
      if (seen !== 1'b1) complete_run();
    end
  endtask : expV

  task waitAct(input logic [3:0] exp);
    for (int i = 0; i < 8 && activeLevels !== exp; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("activeLevels", {12'h0, exp}, {12'h0, activeLevels});
    if (activeLevels !== exp) complete_run();
  endtask : waitAct

  task clr();
    @(posedge ref_clk);
    req <= 16'h0000;
    wdMode <= 1'b0;
    wr(8'hC0, 8'h00);
    wr(8'hA8, 8'h00);
    wr(8'hB8, 8'h00);
    wr(8'hA9, 8'h00);
    wr(8'hB9, 8'h00);
  endtask : clr

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task t_regs();
    logic [7:0] adr [5] = '{8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hC0};
    logic [7:0] msk [5] = '{8'hBF, 8'h3F, 8'hDF, 8'h3F, 8'hDF};
    for (int i = 0; i < 5; i++) rd(adr[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'hFF);
      wr(8'h55, 8'hFF);
      rd(adr[i], msk[i]);
      wr(adr[i], 8'h00);
    end
    rd(8'h55, 8'h00);
  endtask : t_regs

  task t_src(input int n);
    logic [7:0] b;
    b = 8'h01 << n[2:0];
    wr(n < 8 ? 8'hA8 : 8'hB8, b);
    @(posedge ref_clk);
    req[n] <= 1'b1;
    expV(1'b0, 4'h0, 2'd0);
    wr(8'hA8, n < 8 ? (8'h80 | b) : 8'h80);
    if (n == 14) begin
      expV(1'b0, 4'h0, 2'd0);
      @(posedge ref_clk);
      wdMode <= 1'b1;
    end
    expV(1'b1, n[3:0], 2'd0);
    expV(1'b1, n[3:0], 2'd0);
    if (n >= 8) rd(8'hC0, b);
    wr(n < 8 ? 8'hA8 : 8'hB8, n < 8 ? 8'h80 : 8'h00);
    expV(1'b0, 4'h0, 2'd0);
    clr();
  endtask : t_src

  task t_prio();
    wr(8'hA8, 8'hA1);
    wr(8'hA9, 8'h20);
    wr(8'hB9, 8'h20);
    @(posedge ref_clk);
    req <= 16'h0021;
    expV(1'b1, 4'h5, 2'd3);
    wr(8'hA9, 8'h00);
    wr(8'hB9, 8'h00);
    expV(1'b1, 4'h0, 2'd0);
    clr();
    wr(8'hA8, 8'h82);
    wr(8'hB8, 8'h40);
    @(posedge ref_clk);
    wdMode <= 1'b1;
    req <= 16'h4002;
    for (int l = 0; l < 4; l++) begin
      wr(8'hA9, {6'h00, l[0], 1'b0});
      wr(8'hB9, {6'h00, l[1], 1'b0});
      expV(1'b1, 4'hE, l[1:0]);
    end
    clr();
    wr(8'hA8, 8'hA0);
    @(posedge ref_clk);
    req <= 16'h00A0;
    expV(1'b1, 4'h5, 2'd0);
    wr(8'hA8, 8'h80);
    expV(1'b1, 4'h7, 2'd0);
    clr();
  endtask : t_prio

  task t_rst();
    wr(8'hA8, 8'h80);
    wr(8'hB8, 8'h01);
    wr(8'hC0, 8'h01);
    expV(1'b1, 4'h8, 2'd0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk("vectorOut.valid", 16'h0000, {15'h0, vectorOut.valid});
    rd(8'hC0, 8'h00);
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h00);
  endtask : t_rst

  task t_pre();
    wr(8'hA9, 8'h20);
    wr(8'hA8, 8'hA1);
    @(posedge ref_clk);
    takeDelay <= 4'h3;
    takeEn <= 1'b1;
    req[5] <= 1'b1;
    expV(1'b1, 4'h5, 2'd1);
    waitAct(4'h2);
    chk("takenNumber", 16'h0005, {12'h0, takenNumber});
    @(posedge ref_clk);
    req[0] <= 1'b1;
    takeDelay <= 4'h0;
    expV(1'b0, 4'h0, 2'd0);
    wr(8'hA9, 8'h21);
    wr(8'hB9, 8'h01);
    expV(1'b1, 4'h0, 2'd3);
    waitAct(4'hA);
    @(posedge ref_clk);
    req <= 16'h0000;
    retCmd <= 1'b1;
    @(posedge ref_clk);
    retCmd <= 1'b0;
    waitAct(4'h2);
    @(posedge ref_clk);
    retCmd <= 1'b1;
    takeEn <= 1'b0;
    @(posedge ref_clk);
    retCmd <= 1'b0;
    waitAct(4'h0);
    clr();
  endtask : t_pre

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    for (int k = 0; k < 13; k++) t_src(srcs[k]);
    t_prio();
    t_pre();
    t_rst();
    complete_run();
  end
endmodule : grouped_priority_interrupt_ctrl_tb

// [processor_core_model.sv]
// Behavioural model of the processor core that accepts vectors and ends service.
`timescale 1ns/1ps
module processor_core_model (
  input  wire logic                                        ref_clk,
  input  wire logic                                        rst,
  input  wire grouped_priority_interrupt_ctrl_pkg::vector_s vectorOut,
  input  wire logic                                        takeEn,
  input  wire logic [3:0]                                  takeDelay,
  input  wire logic                                        retCmd,
  output logic                                             vectorTaken,
  output logic                                             serviceReturn,
  output logic [3:0]                                       takenNumber
);
  logic [3:0] waitCount;

  // The core only accepts while an offer stands, and never twice in a row,
  // because the offer needs one cycle to clear after an accept.
  always_ff @(posedge ref_clk) begin
    vectorTaken <= 1'b0;
    serviceReturn <= retCmd & ~rst;
    if (rst) begin
      waitCount <= 4'h0;
      takenNumber <= 4'h0;
    end else if (takeEn && vectorOut.valid && !vectorTaken) begin
      if (waitCount >= takeDelay) begin
        vectorTaken <= 1'b1;
        takenNumber <= vectorOut.number;
        waitCount <= 4'h0;
      end else begin
        waitCount <= waitCount + 4'h1;
      end
    end else begin
      waitCount <= 4'h0;
    end
  end
endmodule : processor_core_model
